// ---- pic_regs.svh ----
// Purpose: constants of the position input counter
// Assumes: 25 MHz reference clock, times held in picoseconds
// Notes: cycle counts round a least time up to whole cycles
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

`define PIC_POS_W 32
`define PIC_NCH 5
`define PIC_FCNT_W 6

// clock period and filter times
`define PIC_CLK_PS 40000
`define PIC_FLT0_PS 1950000
`define PIC_FLT1_PS 1000000
`define PIC_FLT2_PS 500000
`define PIC_FLT3_PS 250000
`define PIC_FLT4_PS 125000
`define PIC_FLT5_PS 100000
`define PIC_FLT6_PS 62500
`define PIC_CYC(ps) (((ps) + `PIC_CLK_PS - 1) / `PIC_CLK_PS)

// usable count bandwidth per filter code, in hertz
`define PIC_BW0_HZ 512000
`define PIC_BW1_HZ 1000000
`define PIC_BW2_HZ 2000000
`define PIC_BW3_HZ 4000000
`define PIC_BW4_HZ 8000000
`define PIC_BW5_HZ 10000000
`define PIC_BW6_HZ 16000000

// polarity word and live state bit positions
`define PIC_BIT_A 0
`define PIC_BIT_B 1
`define PIC_BIT_IDX 2
`define PIC_BIT_HOME 3
`define PIC_BIT_SENS 4
`define PIC_BIT_ZTOG 5
`define PIC_BIT_OUT 7

// reset values
`define PIC_RST_FMT 2'h0
`define PIC_RST_FILT 3'h1
`define PIC_RST_RATE 2'h0
`define PIC_RST_POL 8'h00
`define PIC_RST_RUN 1'h1
`define PIC_RST_POS 32'h0000_0000

`endif

// ---- pic_pkg.sv ----
// Purpose: types of the position input counter
// Assumes: constants come from pic_regs.svh
// Notes: enums carry the documented codes
package pic_pkg;

    // input signal format
    typedef enum logic [1:0] {
        PIC_FMT_QUAD = 2'h0,
        PIC_FMT_DUAL = 2'h1,
        PIC_FMT_STEP = 2'h2
    } pic_fmt_t;

    // quadrature multiplier
    typedef enum logic [1:0] {
        PIC_RATE_X4 = 2'h0,
        PIC_RATE_X2 = 2'h1,
        PIC_RATE_X1 = 2'h2
    } pic_rate_t;

    // configuration word written by software
    typedef struct packed {
        logic [7:0] pol;
        logic run;
        pic_fmt_t fmt;
        logic [2:0] filt;
        pic_rate_t rate;
    } pic_cfg_t;

endpackage : pic_pkg

// ---- pic_filter.sv ----
// Purpose: debounce filter for one input channel
// Assumes: din already synchronised to ref_clk
// Notes: output flips only after thresh stable cycles
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_filter (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [`PIC_FCNT_W-1:0] thresh,
    input wire logic din,
    output logic dout
);

    logic [`PIC_FCNT_W-1:0] cnt_reg; // cycles din has differed
    logic [`PIC_FCNT_W-1:0] cnt_next;
    logic dout_reg; // filtered level
    logic dout_next;

    assign dout = dout_reg;

    // a pulse shorter than thresh cycles never reaches dout
    always_comb
    begin
        cnt_next = cnt_reg;
        dout_next = dout_reg;
        if (clk_en)
        begin
            if (din == dout_reg)
                cnt_next = '0;
            else if (cnt_reg >= thresh - `PIC_FCNT_W'(1))
            begin
                dout_next = din;
                cnt_next = '0;
            end
            else
                cnt_next = cnt_reg + `PIC_FCNT_W'(1);
        end
    end

    // registers only
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cnt_reg <= '0;
            dout_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            dout_reg <= dout_next;
        end
    end

    // reset drops dout on a clock edge, so the edge that follows reset is left out
    a_flt_settle: assert property (@(posedge ref_clk)
        disable iff (!reset_n) $past(reset_n) && $changed(dout_reg)
        |-> $past(cnt_reg) == $past(thresh) - 1)
        else $error("filter output changed before its hold time");

endmodule : pic_filter

// ---- pic_counter.sv ----
// Purpose: phase input decode, filtering and 32-bit position counter
// Assumes: single ref_clk domain, pins are asynchronous
// Notes: config is written as one word through cfg_wr
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_counter #(
    parameter bit ENHANCED = 1'b1 // enables filter codes 5 and 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic phase_a_pin,
    input wire logic phase_b_pin,
    input wire logic index_pin,
    input wire logic home_pin,
    input wire logic sensor_pin,
    input wire logic cfg_wr,
    input wire pic_pkg::pic_cfg_t cfg_in,
    input wire logic load_strobe,
    input wire logic [`PIC_POS_W-1:0] load_value,
    output pic_pkg::pic_cfg_t cfg_q,
    output logic [`PIC_POS_W-1:0] position,
    output logic [7:0] live_state,
    output logic dist_step,
    output logic dist_up
);

    logic [`PIC_NCH-1:0] pins; // raw pins
    logic [`PIC_NCH-1:0] meta_reg; // first sync stage
    logic [`PIC_NCH-1:0] meta_next;
    logic [`PIC_NCH-1:0] sync_reg; // second sync stage
    logic [`PIC_NCH-1:0] sync_next;
    logic [`PIC_NCH-1:0] pol_in; // polarity corrected levels
    logic [`PIC_NCH-1:0] flt; // filtered levels
    logic [`PIC_NCH-1:0] prev_reg; // filtered levels one cycle ago
    logic [`PIC_NCH-1:0] prev_next;
    logic [`PIC_FCNT_W-1:0] thresh; // filter length in cycles
    pic_pkg::pic_cfg_t cfg_reg;
    pic_pkg::pic_cfg_t cfg_next;
    logic [`PIC_POS_W-1:0] pos_reg;
    logic [`PIC_POS_W-1:0] pos_next;
    logic ztog_reg; // index seen toggle
    logic ztog_next;
    logic [7:0] live_reg;
    logic [7:0] live_next;
    logic dstep_reg;
    logic dstep_next;
    logic dup_reg;
    logic dup_next;
    logic a_chg; // phase a edge of any kind
    logic b_chg;
    logic a_rise;
    logic b_rise;
    logic step; // one count this cycle
    logic up; // direction of that count

    // every assertion below samples on the rising clock, idle in reset
    default clocking cb_assert @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    assign pins = {sensor_pin, home_pin, index_pin, phase_b_pin, phase_a_pin};

    // outputs straight from flops; read any time, no side effect
    assign position = pos_reg;
    assign cfg_q = cfg_reg;
    assign live_state = live_reg;
    assign dist_step = dstep_reg;
    assign dist_up = dup_reg;

    // two-stage synchroniser, second stage alone is read
    always_comb
    begin
        meta_next = clk_en ? pins : meta_reg;
        sync_next = clk_en ? meta_reg : sync_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    // inversion before decode, so in quadrature a flipped phase reverses direction
    assign pol_in = sync_reg ^ cfg_reg.pol[`PIC_NCH-1:0];

    // filter length; unsupported codes fall back to the default
    always_comb
    begin
        thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT1_PS));
        case (cfg_reg.filt)
            3'h0: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT0_PS));
            3'h1: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT1_PS));
            3'h2: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT2_PS));
            3'h3: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT3_PS));
            3'h4: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT4_PS));
            3'h5:
                if (ENHANCED)
                    thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT5_PS));
            3'h6:
                if (ENHANCED)
                    thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT6_PS));
            default: thresh = `PIC_FCNT_W'(`PIC_CYC(`PIC_FLT1_PS));
        endcase
    end

    // one filter per input channel
    genvar g;
    generate
        for (g = 0; g < `PIC_NCH; g++)
        begin : g_flt
            pic_filter u_flt (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .thresh(thresh),
                .din(pol_in[g]),
                .dout(flt[g])
            );
        end
    endgenerate

    assign a_chg = flt[`PIC_BIT_A] ^ prev_reg[`PIC_BIT_A];
    assign b_chg = flt[`PIC_BIT_B] ^ prev_reg[`PIC_BIT_B];
    assign a_rise = flt[`PIC_BIT_A] & ~prev_reg[`PIC_BIT_A];
    assign b_rise = flt[`PIC_BIT_B] & ~prev_reg[`PIC_BIT_B];

    // decode of the two phases into count steps
    always_comb
    begin
        step = 1'b0;
        up = 1'b0;
        case (cfg_reg.fmt)
            pic_pkg::PIC_FMT_QUAD:
                case (cfg_reg.rate)
                    pic_pkg::PIC_RATE_X4:
                    begin
                        // both phases moving at once is illegal, skip it
                        step = a_chg ^ b_chg;
                        if (a_chg)
                            up = flt[0] ^ prev_reg[1];
                        else
                            up = ~(flt[1] ^ prev_reg[0]);
                    end
                    pic_pkg::PIC_RATE_X2:
                    begin
                        step = a_chg;
                        up = flt[0] ^ flt[1];
                    end
                    pic_pkg::PIC_RATE_X1:
                    begin
                        step = a_rise;
                        up = ~flt[1];
                    end
                    default:
                    begin
                        step = 1'b0;
                        up = 1'b0;
                    end
                endcase
            pic_pkg::PIC_FMT_DUAL:
            begin
                // coincident forward and reverse pulses cancel
                step = a_rise ^ b_rise;
                up = a_rise;
            end
            pic_pkg::PIC_FMT_STEP:
            begin
                step = a_rise;
                up = ~flt[1];
            end
            default:
            begin
                step = 1'b0;
                up = 1'b0;
            end
        endcase
    end

    // config, counter, live state and distance steps
    always_comb
    begin
        cfg_next = cfg_reg;
        pos_next = pos_reg;
        prev_next = prev_reg;
        ztog_next = ztog_reg;
        live_next = live_reg;
        dstep_next = dstep_reg;
        dup_next = dup_reg;
        if (clk_en)
        begin
            if (cfg_wr)
                cfg_next = cfg_in;
            prev_next = flt;
            if (flt[`PIC_BIT_IDX] & ~prev_reg[`PIC_BIT_IDX])
                ztog_next = ~ztog_reg;
            // load wins over a count in the same cycle
            if (load_strobe)
                pos_next = load_value;
            else if (cfg_reg.run && step)
                pos_next = up ? pos_reg + `PIC_POS_W'(1)
                              : pos_reg - `PIC_POS_W'(1);
            live_next = {2'b00, ztog_reg, flt};
            dstep_next = cfg_reg.run & step;
            dup_next = up;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cfg_reg <= '{pol: `PIC_RST_POL, run: `PIC_RST_RUN,
                fmt: pic_pkg::PIC_FMT_QUAD, filt: `PIC_RST_FILT,
                rate: pic_pkg::PIC_RATE_X4};
            pos_reg <= `PIC_RST_POS;
            prev_reg <= '0;
            ztog_reg <= 1'b0;
            live_reg <= 8'h00;
            dstep_reg <= 1'b0;
            dup_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            pos_reg <= pos_next;
            prev_reg <= prev_next;
            ztog_reg <= ztog_next;
            live_reg <= live_next;
            dstep_reg <= dstep_next;
            dup_reg <= dup_next;
        end
    end

    // a cycle in which nothing blocks a count
    sequence s_count_open;
        clk_en && !load_strobe && cfg_reg.run;
    endsequence

    sequence s_count_up;
        s_count_open ##0 step && up;
    endsequence

    a_load_value: assert property (clk_en && load_strobe
        |=> pos_reg == $past(load_value))
        else $error("load value not taken");
    a_stop_hold: assert property (!cfg_reg.run && !load_strobe
        |=> $stable(pos_reg))
        else $error("counter moved while stopped");
    a_count_up: assert property (s_count_up
        |=> pos_reg == $past(pos_reg) + 1)
        else $error("up count wrong");
    a_wrap_max: assert property (s_count_up
        ##0 pos_reg == 32'h7FFF_FFFF |=> pos_reg == 32'h8000_0000)
        else $error("counter did not wrap");
    // checked at the counter, so a lost step in decode fails too
    a_dual_fwd: assert property (s_count_open
        ##0 cfg_reg.fmt == pic_pkg::PIC_FMT_DUAL && a_rise && !b_rise
        |=> pos_reg == $past(pos_reg) + 1)
        else $error("forward pulse not counted up");
    a_step_dir: assert property (s_count_open
        ##0 cfg_reg.fmt == pic_pkg::PIC_FMT_STEP && a_rise
        |=> pos_reg == $past(pos_reg) + ($past(flt[1]) ? 32'hFFFF_FFFF
        : 32'h0000_0001))
        else $error("step direction wrong");
    a_x1_rate: assert property (b_chg && !a_chg
        && cfg_reg.fmt == pic_pkg::PIC_FMT_QUAD
        && cfg_reg.rate != pic_pkg::PIC_RATE_X4 |-> !step)
        else $error("second phase counted at low rate");
    a_dist_step: assert property (clk_en && cfg_reg.run && step
        |=> dstep_reg && dup_reg == $past(up))
        else $error("distance step missing");
    a_live_view: assert property (clk_en
        |=> live_reg[4:0] == $past(flt))
        else $error("live state stale");
    a_reset_dflt: assert property ($rose(reset_n)
        |-> cfg_reg.filt == 3'h1 && cfg_reg.run)
        else $error("reset defaults wrong");

endmodule : pic_counter

// ---- pic_encoder.sv ----
// Purpose: encoder or linear scale model that drives the two phase pins
// Assumes: one step per go pulse, each level held width cycles
// Notes: levels are held between steps, as a real sensor holds them
`timescale 1ns/1ps
module pic_encoder (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic up,
    input wire logic [1:0] fmt,
    input wire logic [7:0] width,
    output logic a_pin,
    output logic b_pin,
    output logic busy
);
    logic [1:0] ph; // quadrature state in gray order, rebuilt from the pins

    initial
    begin
        a_pin = 1'b0;
        b_pin = 1'b0;
        busy = 1'b0;
    end

    // one step per request; the waits keep every level width cycles long
    always @(posedge ref_clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            if (fmt == 2'h0)
            begin
                // rebuilt from the pins so a change of format never skips
                ph = {b_pin, a_pin ^ b_pin};
                ph = up ? ph + 2'h1 : ph - 2'h1;
                a_pin <= ph[1] ^ ph[0]; // a leads b going up
                b_pin <= ph[1];
            end
            else
            begin
                // idle low first; the direction level settles before the clock
                a_pin <= 1'b0;
                b_pin <= (fmt == 2'h2) ? !up : 1'b0;
                repeat (width) @(posedge ref_clk);
                if (fmt == 2'h1 && !up)
                    b_pin <= 1'b1;
                else
                    a_pin <= 1'b1;
                repeat (width) @(posedge ref_clk);
                a_pin <= 1'b0;
                if (fmt == 2'h1)
                    b_pin <= 1'b0;
            end
            repeat (width) @(posedge ref_clk);
            busy <= 1'b0;
        end
    end
endmodule : pic_encoder

// ---- position_input_counter_bench.sv ----
// Purpose: self-checking bench of the position input counter
// Assumes: filter thresholds counted in whole ref_clk cycles
// Notes: every case loads a random base after the pins settle
`timescale 1ns/1ps
`include "pic_regs.svh"
module position_input_counter_bench;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic load_strobe = 1'b0;
    logic home_pin = 1'b0;
    logic index_pin = 1'b0;
    logic sensor_pin = 1'b0;
    logic clk_en = 1'b1;
    logic dist_up;
    logic [31:0] n_up = 32'h0000_0000; // up steps seen
    logic go = 1'b0;
    logic up = 1'b1;
    logic [7:0] width = 8'h04;
    logic [31:0] load_value = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_05d5; // xorshift state, fixed start
    logic [31:0] n_dist = 32'h0000_0000; // distance steps seen
    pic_pkg::pic_cfg_t cfg_in = '0;
    pic_pkg::pic_cfg_t cfg_q;
    logic [31:0] position;
    logic [7:0] live_state;
    logic dist_step;
    logic a_pin;
    logic b_pin;
    logic busy;
    logic [1:0] f;
    logic [2:0] fl;
    int n;
    int n_errors = 0;
    int tests_run = 0;

    always #20 ref_clk = ~ref_clk;

    // counts the pulses handed on to the distance counter
    always @(posedge ref_clk)
    begin
        n_dist <= n_dist + {31'h0000_0000, dist_step};
        n_up <= n_up + {31'h0000_0000, dist_step & dist_up};
    end

    pic_counter pic_counter_i (.ref_clk, .reset_n, .clk_en,
        .phase_a_pin(a_pin), .phase_b_pin(b_pin), .index_pin,
        .home_pin, .sensor_pin, .cfg_wr, .cfg_in, .load_strobe,
        .load_value, .cfg_q, .position, .live_state, .dist_step,
        .dist_up);

    pic_encoder pic_encoder_i (.ref_clk, .go, .up, .fmt(cfg_in.fmt),
        .width, .a_pin, .b_pin, .busy);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // least pulse in cycles that each filter code lets through
    function automatic int thresh(input logic [2:0] c);
        case (c)
            3'h0: return 49;
            3'h1: return 25;
            3'h2: return 13;
            3'h3: return 7;
            3'h4: return 4;
            3'h5: return 3;
            default: return 2;
        endcase
    endfunction : thresh

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : tick

    // long wait after the write so a polarity flip cannot leak into a case
    task automatic write_cfg(input logic [7:0] pol, input logic run,
        input logic [1:0] fm, input logic [2:0] fi, input logic [1:0] rt);
        cfg_in <= {pol, run, fm, fi, rt};
        cfg_wr <= 1'b1;
        tick(1);
        cfg_wr <= 1'b0;
        tick(60);
    endtask : write_cfg

    task automatic load(input logic [31:0] v);
        load_value <= v;
        load_strobe <= 1'b1;
        tick(1);
        load_strobe <= 1'b0;
        tick(2);
    endtask : load

    task automatic steps(input int k, input logic dir, input int w);
        int t;
        for (int i = 0; i < k; i++)
        begin
            up <= dir;
            width <= w[7:0];
            go <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(1);
            t = 0;
            while (busy && t < 1000)
            begin
                tick(1);
                t++;
            end
            if (t == 1000)
            begin
                n_errors++;
                conclude();
            end
        end
        tick(60);
    endtask : steps

    task automatic run_case(input int k, input logic dir, input int w,
        input logic [31:0] delta);
        logic [31:0] v;
        logic [31:0] d0;
        logic [31:0] u0;
        seed = xs(seed);
        v = seed;
        load(v);
        d0 = n_dist;
        u0 = n_up;
        steps(k, dir, w);
        check(position, v + delta);
        check(n_dist - d0, delta[31] ? -delta : delta);
        check(n_up - u0, delta[31] ? 32'h0000_0000 : delta);
    endtask : run_case

    initial
    begin
        tick(4);
        reset_n <= 1'b1;
        tick(1);
        check(cfg_q, 32'h0000_0084);
        check(position, 32'h0000_0000);
        // every multiplier, both directions, two whole cycles
        for (int r = 0; r < 3; r++)
            for (int d = 0; d < 2; d++)
            begin
                write_cfg(8'h00, 1'b1, 2'h0, 3'h6, r[1:0]);
                run_case(8, d[0], 4, d ? 8 >> r : -(8 >> r));
            end
        // random formats; multiplier left random where it must be ignored
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            f = (seed[1:0] == 2'h3) ? 2'h0 : seed[1:0];
            fl = 3'h3 + {1'b0, seed[9:8]};
            n = 1 + seed[6:4];
            write_cfg(8'h00, 1'b1, f, fl, f == 2'h0 ? 2'h0 : seed[3:2]);
            run_case(n, seed[7], thresh(fl) + 1, seed[7] ? n : -n);
        end
        // inverted phase a turns the count round
        home_pin <= 1'b1;
        write_cfg(8'h09, 1'b1, 2'h0, 3'h6, 2'h0);
        check(cfg_q, 32'h0000_0998);
        run_case(8, 1'b1, 4, -8);
        check(live_state, {4'h0, ~home_pin, 1'b0, b_pin, ~a_pin});
        // an index pulse flips the toggle flag; the sensor level shows
        index_pin <= 1'b1;
        sensor_pin <= 1'b1;
        tick(8);
        index_pin <= 1'b0;
        tick(8);
        check(live_state, {4'h3, ~home_pin, 1'b0, b_pin, ~a_pin});
        // stopped counter ignores pulses but still loads
        write_cfg(8'h00, 1'b0, 2'h1, 3'h6, 2'h0);
        run_case(3, 1'b1, 4, 0);
        // silent wrap at the signed limits
        write_cfg(8'h00, 1'b1, 2'h1, 3'h6, 2'h0);
        load(32'h7fff_ffff);
        steps(1, 1'b1, 4);
        check(position, 32'h8000_0000);
        steps(1, 1'b0, 4);
        check(position, 32'h7fff_ffff);
        // a frozen block takes no load
        clk_en <= 1'b0;
        load(32'h1234_5678);
        check(position, 32'h7fff_ffff);
        clk_en <= 1'b1;
        // a reset in mid-run restores every default
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
        check(cfg_q, 32'h0000_0084);
        check(position, 32'h0000_0000);
        // each filter code: a pulse one cycle short is lost, a longer counts
        for (int k = 0; k < 7; k++)
        begin
            write_cfg(8'h00, 1'b1, 2'h1, k[2:0], 2'h0);
            run_case(1, 1'b1, thresh(k[2:0]) - 1, 0);
            run_case(1, 1'b1, thresh(k[2:0]) + 1, 1);
        end
        conclude();
    end
endmodule : position_input_counter_bench
